/* core/cofbd_core.sv */
`timescale 1ns/1ps
module cofbd_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wake_pin,
  output logic sleep_mode
);
  function automatic cofbd_pkg::cofbd_class_t decode_class(input logic [7:0] b);
    cofbd_pkg::cofbd_class_t c;
    c = cofbd_pkg::CLS_UNASSIGNED;
    case (b[7:4])
      4'h0:
        case (b[3:0])
          4'h0: c = cofbd_pkg::CLS_NOP;
          4'h1: c = cofbd_pkg::CLS_SLEEP;
          4'h2, 4'h3, 4'h7: c = cofbd_pkg::CLS_CCR_XFER;
          4'h4, 4'h5, 4'h6: c = cofbd_pkg::CLS_CCR_LOGIC;
          4'h8, 4'h9: c = cofbd_pkg::CLS_ADD;
          4'hA: c = cofbd_pkg::CLS_INC_DEC;
          4'hB: c = cofbd_pkg::CLS_ADDS_SUBS;
          4'hC, 4'hD: c = cofbd_pkg::CLS_MOV;
          4'hE: c = cofbd_pkg::CLS_ADDX;
          default: c = cofbd_pkg::CLS_DAA;
        endcase
      4'h1:
        case (b[3:0])
          4'h0, 4'h1: c = cofbd_pkg::CLS_SHIFT;
          4'h2, 4'h3: c = cofbd_pkg::CLS_ROTATE;
          4'h4, 4'h5, 4'h6: c = cofbd_pkg::CLS_LOGIC;
          4'h7: c = cofbd_pkg::CLS_NOT_NEG;
          4'h8, 4'h9: c = cofbd_pkg::CLS_SUB;
          4'hA: c = cofbd_pkg::CLS_INC_DEC;
          4'hB: c = cofbd_pkg::CLS_ADDS_SUBS;
          4'hC, 4'hD: c = cofbd_pkg::CLS_CMP;
          4'hE: c = cofbd_pkg::CLS_SUBX;
          default: c = cofbd_pkg::CLS_DAS;
        endcase
      4'h2, 4'h3: c = cofbd_pkg::CLS_MOV;
      4'h4: c = cofbd_pkg::CLS_BRANCH;
      4'h5:
        case (b[3:0])
          4'h0: c = cofbd_pkg::CLS_MULXU;
          4'h1: c = cofbd_pkg::CLS_UNSIGNED_DIVIDE_OP;
          4'h4: c = cofbd_pkg::CLS_RTS;
          4'h5: c = cofbd_pkg::CLS_BSR;
          4'h6: c = cofbd_pkg::CLS_RTE;
          4'h9, 4'hA, 4'hB: c = cofbd_pkg::CLS_JMP;
          4'hD, 4'hE, 4'hF: c = cofbd_pkg::CLS_JSR;
          default: c = cofbd_pkg::CLS_UNASSIGNED;
        endcase
      4'h6:
        case (b[3:0])
          4'h0, 4'h1, 4'h2, 4'h3, 4'h7: c = cofbd_pkg::CLS_BIT;
          4'h4, 4'h5, 4'h6: c = cofbd_pkg::CLS_UNASSIGNED;
          default: c = cofbd_pkg::CLS_MOV;
        endcase
      4'h7:
        case (b[3:0])
          4'h8, 4'h9, 4'hA: c = cofbd_pkg::CLS_MOV;
          4'hB: c = cofbd_pkg::CLS_BLOCK_MOVE;
          default: c = cofbd_pkg::CLS_BIT;
        endcase
      4'h8: c = cofbd_pkg::CLS_ADD;
      4'h9: c = cofbd_pkg::CLS_ADDX;
      4'hA: c = cofbd_pkg::CLS_CMP;
      4'hB: c = cofbd_pkg::CLS_SUBX;
      4'hF: c = cofbd_pkg::CLS_MOV;
      default: c = cofbd_pkg::CLS_LOGIC;
    endcase
    return c;
  endfunction

  function automatic logic is_pair(input logic [7:0] b);
    return (b == 8'h10) || (b == 8'h11) || (b == 8'h12) || (b == 8'h13) ||
      (b == 8'h17) || (b == 8'h67) || (b[7:2] == 6'b011101);
  endfunction

  function automatic logic branch_eval(input logic [3:0] cc, input logic [7:0] f);
    logic c, v, z, n, t;
    c = f[cofbd_pkg::FLG_C];
    v = f[cofbd_pkg::FLG_V];
    z = f[cofbd_pkg::FLG_Z];
    n = f[cofbd_pkg::FLG_N];
    case (cc[3:1])
      3'h0: t = 1'b1;
      3'h1: t = ~(c | z);
      3'h2: t = ~c;
      3'h3: t = ~z;
      3'h4: t = ~v;
      3'h5: t = ~n;
      3'h6: t = ~(n ^ v);
      default: t = ~(z | (n ^ v));
    endcase
    return t ^ cc[0];
  endfunction

  function automatic logic [16:0] state_count(input cofbd_pkg::cofbd_class_t c,
                                              input logic [7:0] n);
    logic [16:0] s;
    s = 17'h0_0000;
    case (c)
      cofbd_pkg::CLS_NOP, cofbd_pkg::CLS_SLEEP, cofbd_pkg::CLS_CCR_XFER,
      cofbd_pkg::CLS_CCR_LOGIC: s = {1'b1, cofbd_pkg::ST_SHORT};
      cofbd_pkg::CLS_BRANCH: s = {1'b1, cofbd_pkg::ST_BRANCH};
      cofbd_pkg::CLS_BSR: s = {1'b1, cofbd_pkg::ST_BSR};
      cofbd_pkg::CLS_RTS: s = {1'b1, cofbd_pkg::ST_RTS};
      cofbd_pkg::CLS_RTE: s = {1'b1, cofbd_pkg::ST_RTE};
      cofbd_pkg::CLS_BLOCK_MOVE: s = {1'b1, {6'h00, n, 2'b00} + cofbd_pkg::ST_BLOCK_BASE};
      default: s = 17'h0_0000;
    endcase
    return s;
  endfunction

  logic [15:0] instr;
  logic [15:0] result;
  logic [7:0] condition_flags_reg;
  logic [7:0] count_low_byte_reg;
  logic [7:0] aux;
  logic [7:0] dp_addr;
  logic dp_wr;
  logic dp_rd;
  logic rd_done;
  logic wake_meta;
  logic wake_sync;
  logic [7:0] next_flags;

  logic [7:0] op_byte;
  cofbd_pkg::cofbd_class_t cls;
  logic pair;
  logic second;
  logic sync_hit;
  logic sync_load;
  logic sync_store;
  logic taken;
  logic [16:0] states;
  logic states_valid;
  logic word_arith;
  logic accept;
  logic wr_fire;
  logic exec_fire;
  logic sleep_enter;
  logic [31:0] decode_word;
  logic [31:0] rd_mux;

  assign op_byte = instr[15:8];
  assign cls = decode_class(op_byte);
  assign pair = is_pair(op_byte);
  assign second = pair & instr[cofbd_pkg::PAIR_BIT];
  // sync ops split on bit 7
  assign sync_hit = (op_byte == cofbd_pkg::OP_SYNC) && (instr[6:4] == cofbd_pkg::SYNC_FIELD);
  assign sync_load = sync_hit & ~instr[cofbd_pkg::PAIR_BIT];
  assign sync_store = sync_hit & instr[cofbd_pkg::PAIR_BIT];
  assign taken = (cls == cofbd_pkg::CLS_BRANCH) && branch_eval(op_byte[3:0], condition_flags_reg);
  assign states = state_count(cls, count_low_byte_reg);
  assign states_valid = states[16] & aux[cofbd_pkg::AUX_ONCHIP];
  assign word_arith = (op_byte == cofbd_pkg::OP_ADD_W) || (op_byte == cofbd_pkg::OP_SUB_W) ||
    (op_byte == cofbd_pkg::OP_CMP_W);
  assign decode_word = {14'h0000, sync_store, sync_load, op_byte[3:0], taken,
    (cls == cofbd_pkg::CLS_UNASSIGNED), pair, second, 3'b000, cls};

  assign accept = hsel & htrans[1] & hready;
  assign wr_fire = dp_wr & hready;
  assign exec_fire = wr_fire && (dp_addr == cofbd_pkg::OFS_EXEC);
  assign sleep_enter = exec_fire && (cls == cofbd_pkg::CLS_SLEEP);
  assign hreadyout = ~(dp_rd & ~rd_done);
  assign hresp = 1'b0;
  assign rd_mux =
    (dp_addr == cofbd_pkg::OFS_INSTR) ? {16'h0000, instr} :
    (dp_addr == cofbd_pkg::OFS_DECODE) ? decode_word :
    (dp_addr == cofbd_pkg::OFS_RESULT) ? {16'h0000, result} :
    (dp_addr == cofbd_pkg::OFS_FLAGS) ? {24'h00_0000, condition_flags_reg} :
    (dp_addr == cofbd_pkg::OFS_COUNT) ? {24'h00_0000, count_low_byte_reg} :
    (dp_addr == cofbd_pkg::OFS_AUX) ? {29'h0000_0000, aux[2:0]} :
    (dp_addr == cofbd_pkg::OFS_STATES) ? {15'h0000, states_valid, states[15:0]} :
    (dp_addr == cofbd_pkg::OFS_SLEEP) ? {31'h0000_0000, sleep_mode} :
    32'h0000_0000;

  always_comb
  begin
    next_flags = condition_flags_reg;
    case (cls)
      cofbd_pkg::CLS_ADD, cofbd_pkg::CLS_SUB, cofbd_pkg::CLS_CMP:
        if (word_arith)
          next_flags[cofbd_pkg::FLG_H] = aux[cofbd_pkg::AUX_C11];
      cofbd_pkg::CLS_ADDX, cofbd_pkg::CLS_SUBX:
        if (result[7:0] != 8'h00)
          next_flags[cofbd_pkg::FLG_Z] = 1'b0;
      cofbd_pkg::CLS_DAA, cofbd_pkg::CLS_DAS:
        next_flags[cofbd_pkg::FLG_C] = aux[cofbd_pkg::AUX_DEC];
      cofbd_pkg::CLS_UNSIGNED_DIVIDE_OP:
      begin
        next_flags[cofbd_pkg::FLG_N] = result[7];
        if (result[7:0] != 8'h00)
          next_flags[cofbd_pkg::FLG_Z] = 1'b0;
      end
      default: next_flags = condition_flags_reg;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      rd_done <= 1'b0;
      dp_addr <= 8'h00;
    end
    else if (hready)
    begin
      dp_wr <= accept & hwrite;
      dp_rd <= accept & ~hwrite;
      rd_done <= 1'b0;
      if (accept)
        dp_addr <= haddr[7:0];
    end
    else
      rd_done <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (dp_rd & ~rd_done)
      hrdata <= rd_mux;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr <= cofbd_pkg::INSTR_RST;
      result <= cofbd_pkg::RESULT_RST;
      count_low_byte_reg <= cofbd_pkg::COUNT_RST;
      aux <= cofbd_pkg::AUX_RST;
    end
    else if (wr_fire)
    begin
      if (dp_addr == cofbd_pkg::OFS_INSTR)
        instr <= hwdata[15:0];
      if (dp_addr == cofbd_pkg::OFS_RESULT)
        result <= hwdata[15:0];
      if (dp_addr == cofbd_pkg::OFS_COUNT)
        count_low_byte_reg <= hwdata[7:0];
      if (dp_addr == cofbd_pkg::OFS_AUX)
        aux <= {5'b00000, hwdata[2:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      condition_flags_reg <= cofbd_pkg::FLAGS_RST;
    else if (exec_fire)
      condition_flags_reg <= next_flags;
    else if (wr_fire && (dp_addr == cofbd_pkg::OFS_FLAGS))
      condition_flags_reg <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
      sleep_mode <= 1'b0;
    end
    else
    begin
      wake_meta <= wake_pin;
      wake_sync <= wake_meta;
      if (sleep_enter)
        sleep_mode <= 1'b1;
      else if (wake_sync)
        sleep_mode <= 1'b0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_exec_div;
    exec_fire && (cls == cofbd_pkg::CLS_UNSIGNED_DIVIDE_OP);
  endsequence
  sequence s_rd_start;
    accept && !hwrite;
  endsequence

  a_read_wait: assert property (s_rd_start |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_pair_select: assert property (
    wr_fire && (dp_addr == cofbd_pkg::OFS_INSTR) |=>
      second == (is_pair($past(hwdata[15:8])) && $past(hwdata[7])))
    else $error("pair member select wrong");
  a_half_carry: assert property (
    exec_fire && word_arith |=>
      condition_flags_reg[cofbd_pkg::FLG_H] == $past(aux[cofbd_pkg::AUX_C11]))
    else $error("half carry not from bit 11");
  a_ext_zero: assert property (
    exec_fire && ((cls == cofbd_pkg::CLS_ADDX) || (cls == cofbd_pkg::CLS_SUBX)) |=>
      condition_flags_reg[cofbd_pkg::FLG_Z] == (($past(result[7:0]) == 8'h00) &&
      $past(condition_flags_reg[cofbd_pkg::FLG_Z])))
    else $error("extended zero flag wrong");
  a_decimal_carry: assert property (
    exec_fire && ((cls == cofbd_pkg::CLS_DAA) || (cls == cofbd_pkg::CLS_DAS)) |=>
      condition_flags_reg[cofbd_pkg::FLG_C] == $past(aux[cofbd_pkg::AUX_DEC]))
    else $error("decimal carry wrong");
  a_block_count: assert property (
    wr_fire && (dp_addr == cofbd_pkg::OFS_COUNT) ##1 (cls == cofbd_pkg::CLS_BLOCK_MOVE) |->
      states[15:0] == ({6'h00, $past(hwdata[7:0]), 2'b00} + 16'h0008))
    else $error("block move count wrong");
  a_div_negative: assert property (
    s_exec_div |=> condition_flags_reg[cofbd_pkg::FLG_N] == $past(result[7]))
    else $error("divide negative flag wrong");
  a_div_zero: assert property (
    s_exec_div and (result[7:0] != 8'h00) |=> !condition_flags_reg[cofbd_pkg::FLG_Z])
    else $error("divide zero flag not cleared");
  a_sleep_enter: assert property (
    sleep_enter |=> sleep_mode)
    else $error("sleep not entered");
  a_unassigned_hold: assert property (
    exec_fire && (cls == cofbd_pkg::CLS_UNASSIGNED) |=> $stable(condition_flags_reg))
    else $error("unassigned byte changed flags");
  a_onchip_count: assert property (
    !aux[cofbd_pkg::AUX_ONCHIP] |-> !states_valid)
    else $error("count valid off-chip");
endmodule

/* core/cofbd_pkg.sv */
package cofbd_pkg;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_DECODE = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_AUX = 8'h14;
  localparam logic [7:0] OFS_STATES = 8'h18;
  localparam logic [7:0] OFS_EXEC = 8'h1C;
  localparam logic [7:0] OFS_SLEEP = 8'h20;
  localparam int FLG_H = 5;
  localparam int FLG_N = 3;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_C = 0;
  localparam int AUX_C11 = 0;
  localparam int AUX_DEC = 1;
  localparam int AUX_ONCHIP = 2;
  localparam int PAIR_BIT = 7;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h80;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h04;
  localparam logic [7:0] OP_ADD_W = 8'h09;
  localparam logic [7:0] OP_SUB_W = 8'h19;
  localparam logic [7:0] OP_CMP_W = 8'h1D;
  localparam logic [7:0] OP_SYNC = 8'h6A;
  localparam logic [2:0] SYNC_FIELD = 3'h4;
  localparam logic [15:0] ST_SHORT = 16'h0002;
  localparam logic [15:0] ST_BRANCH = 16'h0004;
  localparam logic [15:0] ST_BSR = 16'h0006;
  localparam logic [15:0] ST_RTS = 16'h0008;
  localparam logic [15:0] ST_RTE = 16'h000A;
  localparam logic [15:0] ST_BLOCK_BASE = 16'h0008;
  typedef enum logic [4:0] {
    CLS_NOP = 5'b00000,
    CLS_SLEEP = 5'b00001,
    CLS_CCR_XFER = 5'b00010,
    CLS_CCR_LOGIC = 5'b00011,
    CLS_ADD = 5'b00100,
    CLS_SUB = 5'b00101,
    CLS_CMP = 5'b00110,
    CLS_INC_DEC = 5'b00111,
    CLS_ADDS_SUBS = 5'b01000,
    CLS_MOV = 5'b01001,
    CLS_ADDX = 5'b01010,
    CLS_SUBX = 5'b01011,
    CLS_DAA = 5'b01100,
    CLS_DAS = 5'b01101,
    CLS_SHIFT = 5'b01110,
    CLS_ROTATE = 5'b01111,
    CLS_LOGIC = 5'b10000,
    CLS_NOT_NEG = 5'b10001,
    CLS_BRANCH = 5'b10010,
    CLS_MULXU = 5'b10011,
    CLS_UNSIGNED_DIVIDE_OP = 5'b10100,
    CLS_RTS = 5'b10101,
    CLS_BSR = 5'b10110,
    CLS_RTE = 5'b10111,
    CLS_JMP = 5'b11000,
    CLS_JSR = 5'b11001,
    CLS_BIT = 5'b11010,
    CLS_BLOCK_MOVE = 5'b11011,
    CLS_UNASSIGNED = 5'b11111
  } cofbd_class_t;
endpackage

/* verification/cofbd_bench.sv */
`timescale 1ns/1ps
module cofbd_bench;
  localparam logic [7:0] AI = cofbd_pkg::OFS_INSTR;
  localparam logic [7:0] AD = cofbd_pkg::OFS_DECODE;
  localparam logic [7:0] AR = cofbd_pkg::OFS_RESULT;
  localparam logic [7:0] AF = cofbd_pkg::OFS_FLAGS;
  localparam logic [7:0] AC = cofbd_pkg::OFS_COUNT;
  localparam logic [7:0] AA = cofbd_pkg::OFS_AUX;
  localparam logic [7:0] AS = cofbd_pkg::OFS_STATES;
  localparam logic [7:0] AE = cofbd_pkg::OFS_EXEC;
  localparam logic [7:0] AP = cofbd_pkg::OFS_SLEEP;
  localparam logic [31:0] M8 = 32'h0000_00FF;
  localparam logic [31:0] MS = 32'h0001_FFFF;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic wake_pin;
  logic sleep_mode;
  logic [31:0] q;
  int n_fail;
  int num_checks;

  cofbd_core dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wake_pin(wake_pin),
    .sleep_mode(sleep_mode)
  );

  always #5 hclk = ~hclk;

  task test_done;
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  // wait for hready high at a falling edge, take hrdata there
  task automatic wt;
    int k;
    k = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && k < 20)
    begin
      k++;
      @(negedge hclk);
    end
    if (k == 20)
      chk(32'h0000_0000, 32'h0000_0001);
    q = hrdata;
    @(posedge hclk);
  endtask

  task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wt();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(a, 1'b1, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xf(a, 1'b0, 32'h0000_0000);
    chk(q & m, e);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic dec(input logic [15:0] op, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    wr(AI, {16'h0, op});
    rc(a, m, e);
  endtask

  task automatic dc(input logic [15:0] op, input cofbd_pkg::cofbd_class_t c);
    dec(op, AD, 32'h0000_001F, {27'h0, c});
  endtask

  task automatic br(input logic [15:0] op, input logic t);
    dec(op, AD, 32'h0000_081F, {20'h0, t, 6'h0, cofbd_pkg::CLS_BRANCH});
  endtask

  task automatic fl(input logic [15:0] op, input logic [7:0] x, input logic [15:0] r,
                    input logic [7:0] f, input logic [31:0] m, input logic [7:0] e);
    wr(AI, {16'h0, op});
    wr(AA, {24'h0, x});
    wr(AR, {16'h0, r});
    wr(AF, {24'h0, f});
    wr(AE, 32'h0000_0001);
    rc(AF, m, {24'h0, e});
  endtask

  task automatic t_reset;
    rc(AF, M8, 32'h0000_0080);
    rc(AA, M8, 32'h0000_0004);
    rc(AI, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rc(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask

  task automatic t_class;
    dc(16'h0000, cofbd_pkg::CLS_NOP);
    dc(16'h0100, cofbd_pkg::CLS_SLEEP);
    dc(16'h0400, cofbd_pkg::CLS_CCR_LOGIC);
    dc(16'h09FF, cofbd_pkg::CLS_ADD);
    dc(16'h0E00, cofbd_pkg::CLS_ADDX);
    dc(16'h1D00, cofbd_pkg::CLS_CMP);
    dc(16'h1F00, cofbd_pkg::CLS_DAS);
    dc(16'h5100, cofbd_pkg::CLS_UNSIGNED_DIVIDE_OP);
    dc(16'h5600, cofbd_pkg::CLS_RTE);
    dc(16'h7B5C, cofbd_pkg::CLS_BLOCK_MOVE);
  endtask

  task automatic t_pair;
    dec(16'h1700, AD, 32'h0000_0300, 32'h0000_0200);
    dec(16'h1780, AD, 32'h0000_0300, 32'h0000_0300);
    dec(16'h6780, AD, 32'h0000_0300, 32'h0000_0300);
    dec(16'h0980, AD, 32'h0000_0300, 32'h0000_0000);
    dc(16'h1780, cofbd_pkg::CLS_NOT_NEG);
  endtask

  task automatic t_sync;
    dec(16'h6A40, AD, 32'h0003_001F, {14'h0, 2'b01, 11'h0, cofbd_pkg::CLS_MOV});
    dec(16'h6AC0, AD, 32'h0003_001F, {14'h0, 2'b10, 11'h0, cofbd_pkg::CLS_MOV});
    dec(16'h6A80, AD, 32'h0003_001F, {14'h0, 2'b00, 11'h0, cofbd_pkg::CLS_MOV});
    dc(16'h6DF0, cofbd_pkg::CLS_MOV);
    dc(16'h6D70, cofbd_pkg::CLS_MOV);
  endtask

  task automatic t_branch;
    wr(AF, 32'h0000_0080);
    br(16'h4000, 1'b1);
    br(16'h4100, 1'b0);
    br(16'h4400, 1'b1);
    br(16'h4500, 1'b0);
    wr(AF, 32'h0000_0081);
    br(16'h4000, 1'b1);
    br(16'h4400, 1'b0);
    br(16'h4500, 1'b1);
  endtask

  task automatic t_states;
    wr(AA, 32'h0000_0004);
    dec(16'h0000, AS, MS, 32'h0001_0002);
    dec(16'h0100, AS, MS, 32'h0001_0002);
    wr(AC, 32'h0000_0000);
    dec(16'h7B5C, AS, MS, 32'h0001_0008);
    wr(AC, 32'h0000_00FF);
    rc(AS, MS, 32'h0001_0404);
    wr(AC, 32'h0000_0003);
    rc(AS, MS, 32'h0001_0014);
    wr(AA, 32'h0000_0000);
    rc(AS, 32'h0001_0000, 32'h0000_0000);
  endtask

  task automatic t_flags;
    fl(16'h0900, 8'h05, 16'h0000, 8'h80, M8, 8'hA0);
    fl(16'h0900, 8'h04, 16'h0000, 8'hA0, M8, 8'h80);
    fl(16'h1900, 8'h05, 16'h0000, 8'h80, M8, 8'hA0);
    fl(16'h1D00, 8'h04, 16'h0000, 8'hA0, M8, 8'h80);
    fl(16'h0E00, 8'h04, 16'h0100, 8'h84, M8, 8'h84);
    fl(16'h0E00, 8'h04, 16'h0001, 8'h84, M8, 8'h80);
    fl(16'h1E00, 8'h04, 16'h0000, 8'h80, M8, 8'h80);
    fl(16'h1E00, 8'h04, 16'h0010, 8'h84, M8, 8'h80);
    fl(16'h0F00, 8'h06, 16'h0000, 8'h80, M8, 8'h81);
    fl(16'h1F00, 8'h04, 16'h0000, 8'h81, M8, 8'h80);
    fl(16'h5100, 8'h04, 16'h0080, 8'h84, M8, 8'h88);
    fl(16'h5100, 8'h04, 16'h0001, 8'h8C, M8, 8'h80);
    fl(16'h5100, 8'h04, 16'h0000, 8'h88, 32'h0000_00FB, 8'h80);
    fl(16'h5200, 8'h07, 16'h0055, 8'hAF, M8, 8'hAF);
    dec(16'h6400, AD, 32'h0000_0400, 32'h0000_0400);
  endtask

  task automatic t_sleep;
    int k;
    wr(AI, 32'h0000_0180);
    wr(AE, 32'h0000_0001);
    rc(AP, 32'h0000_0001, 32'h0000_0001);
    wake_pin <= 1'b1;
    k = 0;
    @(negedge hclk);
    while (sleep_mode !== 1'b0 && k < 8)
    begin
      k++;
      @(negedge hclk);
    end
    chk({31'h0, sleep_mode}, 32'h0000_0000);
    @(posedge hclk);
    wake_pin <= 1'b0;
    rc(AP, 32'h0000_0001, 32'h0000_0000);
  endtask

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    wake_pin = 1'b0;
    n_fail = 0;
    num_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_class();
    t_pair();
    t_sync();
    t_branch();
    t_states();
    t_flags();
    t_sleep();
    test_done();
  end

  initial
  begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule
